// ==== include/ams_pkg.sv ====
// Shared constants and types for the ISA address and memory command block.
package ams_pkg;

  // Clock period of the block in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Address strobe phase and command phase lengths in nanoseconds.
  localparam int unsigned ALE_TIME_NS = 40;
  localparam int unsigned CMD_TIME_NS = 250;

  // Cycle counts for the phases above, rounded up to whole cycles.
  localparam int unsigned TMR_W = 5;
  localparam logic [TMR_W-1:0] ALE_CYCLES = TMR_W'((ALE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CMD_CYCLES = TMR_W'((CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_EXPIRE = 5'h01;
  localparam logic [TMR_W-1:0] TMR_RESET = 5'h00;

  // Bus widths and address field positions.
  localparam int unsigned REQ_ADDR_W = 32;
  localparam int unsigned LA_W = 7;
  localparam int unsigned SA_W = 20;
  localparam int unsigned LA_LSB = 17;
  localparam int unsigned LA_MSB = 23;
  localparam int unsigned IO_ADDR_MSB = 15;
  localparam int unsigned ONE_MB_BIT = 20;
  localparam int unsigned SIXTEEN_MB_BIT = 24;

  // Pin levels after reset.
  localparam logic CMD_IDLE_N = 1'b1;
  localparam logic UPPER_BYTE_ENABLE_N_RESET_N = 1'b1;
  localparam logic [LA_W-1:0] LA_RESET = 7'h00;
  localparam logic [SA_W-1:0] SA_RESET = 20'h00000;

  // Kind of cycle requested by the bridge core.
  typedef enum logic [2:0] {
    AMS_MEM_RD = 3'b000,
    AMS_MEM_WR = 3'b001,
    AMS_IO_RD = 3'b010,
    AMS_IO_WR = 3'b011,
    AMS_REFRESH = 3'b100,
    AMS_DMA_RD = 3'b101,
    AMS_DMA_WR = 3'b110,
    AMS_FAST_DMA = 3'b111
  } ams_kind_type;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_END = 3'b011,
    ST_EXT = 3'b100
  } ams_state_type;

endpackage

// ==== hdl/ams_cycle_timer.sv ====
`timescale 1ns/1ns
// Down counter that times one phase of a bus cycle.
module ams_cycle_timer
  import ams_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Load and status.
  input wire logic load_i,
  input wire logic [TMR_W-1:0] count_i,
  output logic expired_o
);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  // Load wins; otherwise count down to zero and stop.
  assign cnt_nxt = load_i ? count_i : ((cnt_r != TMR_RESET) ? cnt_r - TMR_EXPIRE : cnt_r);
  assign expired_o = (cnt_r == TMR_EXPIRE);

  // Counter register.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= TMR_RESET;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

// ==== hdl/ams_addr_map.sv ====
`timescale 1ns/1ns
// Maps a requested cycle onto address pin values and command enables.
module ams_addr_map
  import ams_pkg::*;
(
  // Request fields.
  input wire ams_kind_type kind_i,
  input wire logic [REQ_ADDR_W-1:0] addr_i,
  input wire logic hi_byte_i,
  // Mapped values.
  output logic [LA_W-1:0] la_o,
  output logic [SA_W-1:0] sa_o,
  output logic upper_byte_enable_n_n_o,
  output logic addr_drive_o,
  output logic rd_o,
  output logic wr_o,
  output logic below_1m_o
);

  logic is_io;
  logic is_fast;
  logic below_16m;

  // Cycle class decode.
  assign is_io = (kind_i == AMS_IO_RD) || (kind_i == AMS_IO_WR);
  assign is_fast = (kind_i == AMS_FAST_DMA);
  assign below_16m = (addr_i[REQ_ADDR_W-1:SIXTEEN_MB_BIT] == '0);
  assign below_1m_o = (addr_i[REQ_ADDR_W-1:ONE_MB_BIT] == '0);

  assign la_o = addr_i[LA_MSB:LA_LSB];
  // Byte address; shared bits match, I/O uses low bits only.
  assign sa_o = is_io ? {4'h0, addr_i[IO_ADDR_MSB:0]} : addr_i[SA_W-1:0];
  // High byte enable, negated on refresh.
  assign upper_byte_enable_n_n_o = (kind_i == AMS_REFRESH) ? 1'b1 : ~hi_byte_i;
  assign addr_drive_o = ~is_fast;

  // Read command for memory, refresh and low DMA.
  assign rd_o = (kind_i == AMS_MEM_RD) || (kind_i == AMS_REFRESH) || ((kind_i == AMS_DMA_RD) && below_16m);
  // Write command for memory and low DMA.
  assign wr_o = (kind_i == AMS_MEM_WR) || ((kind_i == AMS_DMA_WR) && below_16m);

endmodule

// ==== hdl/ams_isa_addr_mem.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Address, high byte enable and wide select are undriven during reset.
// - Upper unlatched address picks a 128 Kbyte section within 16 Mbytes.
// - Byte address bits 19 to 17 equal unlatched bits in memory cycles.
// - I/O cycles carry their address on byte address bits 15 to 0 only.
// - Byte address is driven when we own the bus, input otherwise.
// - Fast DMA transfers need not drive valid address values.
// - High byte enable is asserted when the upper data byte moves.
// - High byte enable stays negated through refresh cycles.
// - We drive wide select low for external master cycles forwarded upstream.
// - External master keeps the bus until it negates ownership.
// - Memory read is output as master, input when another owns bus.
// - Memory read is driven during refresh cycles.
// - Memory write is output as owner, input when another owns bus.
// - Compatible DMA issues memory commands only below 16 Mbytes.
// - Fast DMA keeps both memory commands inactive.
// - Address latch strobe marks valid address; upper address latched at fall.
// - Low memory strobes are delayed command copies, below 1 Mbyte only.
module ams_isa_addr_mem
  import ams_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Cycle requests from the bridge core.
  input wire logic req_valid_i,
  input wire ams_kind_type req_kind_i,
  input wire logic [REQ_ADDR_W-1:0] req_addr_i,
  input wire logic req_hi_byte_i,
  output logic req_ready_o,
  output logic req_done_o,
  // Bus ownership.
  input wire logic dma_grant_n_i,
  input wire logic ext_master_n_i,
  output logic ext_owner_o,
  // Window of upper address sections forwarded to PCI memory.
  input wire logic [LA_W-1:0] fwd_base_i,
  input wire logic [LA_W-1:0] fwd_top_i,
  // Unlatched upper address pins.
  input wire logic [LA_W-1:0] unlatched_upper_addr_i,
  output logic [LA_W-1:0] unlatched_upper_addr_o,
  output logic unlatched_upper_addr_oe_o,
  // System byte address pins.
  input wire logic [SA_W-1:0] system_byte_addr_i,
  output logic [SA_W-1:0] system_byte_addr_o,
  output logic system_byte_addr_oe_o,
  // High byte enable pin.
  input wire logic upper_byte_enable_n_i,
  output logic upper_byte_enable_n_o,
  output logic upper_byte_enable_n_oe_o,
  // Open-drain wide memory select pin.
  input wire logic wide_memory_select_n_i,
  output logic wide_memory_select_n_o,
  output logic wide_memory_select_n_oe_o,
  // Memory command pins.
  input wire logic mem_read_cmd_n_i,
  output logic mem_read_cmd_n_o,
  output logic mem_read_cmd_n_oe_o,
  input wire logic mem_write_cmd_n_i,
  output logic mem_write_cmd_n_o,
  output logic mem_write_cmd_n_oe_o,
  // Address strobe and low memory strobes.
  output logic addr_latch_strobe_o,
  output logic low_mem_read_cmd_n_o,
  output logic low_mem_write_cmd_n_o
);

  // Sequencer and latched request.
  ams_state_type state_r;
  ams_state_type state_nxt;
  ams_kind_type kind_r;
  logic [REQ_ADDR_W-1:0] addr_r;
  logic hi_r;

  // Pin registers.
  logic [LA_W-1:0] la_r;
  logic la_oe_r;
  logic [SA_W-1:0] sa_r;
  logic sa_oe_r;
  logic upper_byte_enable_n_n_r;
  logic upper_byte_enable_n_oe_r;
  logic memcs_oe_r;
  logic memcs_lvl_r;
  logic rd_n_r;
  logic wr_n_r;
  logic cmd_oe_r;
  logic ale_r;
  logic low_rd_n_r;
  logic low_wr_n_r;
  logic ready_r;
  logic done_r;
  logic ext_r;

  // Mapped values of the latched request.
  logic [LA_W-1:0] map_la;
  logic [SA_W-1:0] map_sa;
  logic map_upper_byte_enable_n_n;
  logic map_drive;
  logic map_rd;
  logic map_wr;
  logic map_below_1m;

  // Timer control and decodes.
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_expired;
  logic take_req;
  logic ext_take;
  logic ext_release;
  logic ext_in_window;
  logic ext_below_1m;
  logic own_rd_n;
  logic own_wr_n;
  logic ale_nxt;

  ams_addr_map u_map (
    .kind_i(take_req ? req_kind_i : kind_r), // Map the request being taken at once, so pins match the strobe.
    .addr_i(take_req ? req_addr_i : addr_r),
    .hi_byte_i(take_req ? req_hi_byte_i : hi_r),
    .la_o(map_la),
    .sa_o(map_sa),
    .upper_byte_enable_n_n_o(map_upper_byte_enable_n_n),
    .addr_drive_o(map_drive),
    .rd_o(map_rd),
    .wr_o(map_wr),
    .below_1m_o(map_below_1m)
  );

  ams_cycle_timer u_tmr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .expired_o(tmr_expired)
  );

  // Handover only when the master shows ownership after its grant.
  assign ext_take = (state_r == ST_IDLE) && !ext_master_n_i && !dma_grant_n_i;
  // The bus is given back only when ownership is negated.
  assign ext_release = (state_r == ST_EXT) && ext_master_n_i;
  assign take_req = (state_r == ST_IDLE) && !ext_take && req_valid_i && ready_r;

  // Forward decode uses the upper address alone.
  assign ext_in_window = (unlatched_upper_addr_i >= fwd_base_i) && (unlatched_upper_addr_i <= fwd_top_i);
  assign ext_below_1m = (unlatched_upper_addr_i[LA_W-1:ONE_MB_BIT-LA_LSB] == '0);

  // Phase timer loads on entry to the address and command phases.
  assign tmr_load = take_req || ((state_r == ST_ADDR) && tmr_expired);
  assign tmr_count = take_req ? ALE_CYCLES : CMD_CYCLES;

  // Next sequencer state.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (ext_take)
          state_nxt = ST_EXT;
        else if (take_req)
          state_nxt = ST_ADDR;
      end
      ST_ADDR:
      begin
        if (tmr_expired)
          state_nxt = ST_CMD;
      end
      ST_CMD:
      begin
        if (tmr_expired)
          state_nxt = ST_END;
      end
      ST_END:
        state_nxt = ST_IDLE;
      ST_EXT:
      begin
        if (ext_release)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Commands are asserted only in the command phase of our own cycle.
  assign own_rd_n = !((state_nxt == ST_CMD) && map_rd);
  assign own_wr_n = !((state_nxt == ST_CMD) && map_wr);
  // Strobe marks the address phase and stays high under an external master.
  assign ale_nxt = (state_nxt == ST_ADDR) || (state_nxt == ST_EXT);

  // State and latched request.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      kind_r <= AMS_MEM_RD;
      addr_r <= '0;
      hi_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (take_req)
      begin
        kind_r <= req_kind_i;
        addr_r <= req_addr_i;
        hi_r <= req_hi_byte_i;
      end
    end
  end

  // Address drivers: off in reset, on only for own cycles.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      la_r <= LA_RESET;
      sa_r <= SA_RESET;
      upper_byte_enable_n_n_r <= UPPER_BYTE_ENABLE_N_RESET_N;
      la_oe_r <= 1'b0;
      sa_oe_r <= 1'b0;
      upper_byte_enable_n_oe_r <= 1'b0;
    end
    else if (state_nxt == ST_EXT || state_nxt == ST_IDLE)
    begin
      la_oe_r <= 1'b0;
      sa_oe_r <= 1'b0;
      upper_byte_enable_n_oe_r <= 1'b0;
    end
    else
    begin
      la_r <= map_la;
      sa_r <= map_sa;
      upper_byte_enable_n_n_r <= map_upper_byte_enable_n_n;
      // Fast transfers leave the address lines released.
      la_oe_r <= map_drive;
      sa_oe_r <= map_drive;
      upper_byte_enable_n_oe_r <= 1'b1;
    end
  end

  // Memory commands: driven except while an external master owns, released then.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_n_r <= CMD_IDLE_N;
      wr_n_r <= CMD_IDLE_N;
      cmd_oe_r <= 1'b1;
      ale_r <= 1'b0;
    end
    else
    begin
      rd_n_r <= own_rd_n;
      wr_n_r <= own_wr_n;
      cmd_oe_r <= (state_nxt != ST_EXT);
      ale_r <= ale_nxt;
    end
  end

  // Wide select pulled low during forwarded external master cycles.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      memcs_oe_r <= 1'b0;
      memcs_lvl_r <= 1'b0;
      ext_r <= 1'b0;
    end
    else
    begin
      memcs_oe_r <= (state_r == ST_EXT) && (state_nxt == ST_EXT) && ext_in_window;
      memcs_lvl_r <= 1'b0;
      ext_r <= (state_nxt == ST_EXT);
    end
  end

  // Low memory strobes follow the commands one cycle later, below 1 Mbyte.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      low_rd_n_r <= CMD_IDLE_N;
      low_wr_n_r <= CMD_IDLE_N;
    end
    else if (state_r == ST_EXT)
    begin
      low_rd_n_r <= mem_read_cmd_n_i || !ext_below_1m;
      low_wr_n_r <= mem_write_cmd_n_i || !ext_below_1m;
    end
    else
    begin
      low_rd_n_r <= rd_n_r || !map_below_1m;
      low_wr_n_r <= wr_n_r || !map_below_1m;
    end
  end

  // Request handshake: ready in idle, one-cycle done at the end of a cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ready_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      ready_r <= (state_nxt == ST_IDLE) && !take_req;
      done_r <= (state_r == ST_END);
    end
  end

  // Pin and status outputs come straight from the registers.
  assign unlatched_upper_addr_o = la_r;
  assign unlatched_upper_addr_oe_o = la_oe_r;
  assign system_byte_addr_o = sa_r;
  assign system_byte_addr_oe_o = sa_oe_r;
  assign upper_byte_enable_n_o = upper_byte_enable_n_n_r;
  assign upper_byte_enable_n_oe_o = upper_byte_enable_n_oe_r;
  assign wide_memory_select_n_o = memcs_lvl_r;
  assign wide_memory_select_n_oe_o = memcs_oe_r;
  assign mem_read_cmd_n_o = rd_n_r;
  assign mem_read_cmd_n_oe_o = cmd_oe_r;
  assign mem_write_cmd_n_o = wr_n_r;
  assign mem_write_cmd_n_oe_o = cmd_oe_r;
  assign addr_latch_strobe_o = ale_r;
  assign low_mem_read_cmd_n_o = low_rd_n_r;
  assign low_mem_write_cmd_n_o = low_wr_n_r;
  assign req_ready_o = ready_r;
  assign req_done_o = done_r;
  assign ext_owner_o = ext_r;

endmodule

// ==== tb/ams_isa_addr_mem_assertions.sv ====
`timescale 1ns/1ns
// Port checks for the address and memory command block.
module ams_isa_addr_mem_checker
  import ams_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Requests and ownership.
  input wire logic req_valid_i,
  input wire ams_kind_type req_kind_i,
  input wire logic [REQ_ADDR_W-1:0] req_addr_i,
  input wire logic req_hi_byte_i,
  input wire logic req_ready_o,
  input wire logic dma_grant_n_i,
  input wire logic ext_master_n_i,
  input wire logic ext_owner_o,
  // Pin drivers.
  input wire logic [LA_W-1:0] unlatched_upper_addr_o,
  input wire logic [SA_W-1:0] system_byte_addr_o,
  input wire logic system_byte_addr_oe_o,
  input wire logic upper_byte_enable_n_o,
  input wire logic mem_read_cmd_n_o,
  input wire logic mem_read_cmd_n_oe_o,
  input wire logic mem_write_cmd_n_o,
  input wire logic mem_write_cmd_n_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A request is taken when ready meets valid and no takeover wins.
  wire grab = !ext_master_n_i && !dma_grant_n_i;
  wire take = req_valid_i && req_ready_o && !grab;
  wire idle_cmd = mem_read_cmd_n_o && mem_write_cmd_n_o;

  upper_addr_a: assert property (take && req_kind_i == AMS_MEM_RD |=>
    unlatched_upper_addr_o == $past(req_addr_i[23:17])) else $error("upper address wrong");
  addr_overlap_a: assert property (mem_read_cmd_n_oe_o && !idle_cmd && system_byte_addr_oe_o |->
    system_byte_addr_o[19:17] == unlatched_upper_addr_o[2:0]) else $error("address overlap differs");
  io_addr_a: assert property (take && req_kind_i inside {AMS_IO_RD, AMS_IO_WR} |=>
    system_byte_addr_o == {4'h0, $past(req_addr_i[15:0])}) else $error("io address wrong");
  high_byte_a: assert property (take && req_hi_byte_i && req_kind_i inside {AMS_MEM_RD, AMS_MEM_WR} |=>
    !upper_byte_enable_n_o) else $error("high byte enable not asserted");
  refresh_byte_a: assert property (take && req_kind_i == AMS_REFRESH |=>
    upper_byte_enable_n_o [*8]) else $error("high byte enable asserted in refresh");
  refresh_read_a: assert property (take && req_kind_i == AMS_REFRESH |->
    ##3 !mem_read_cmd_n_o && mem_write_cmd_n_o) else $error("refresh read missing");
  dma_high_a: assert property (take && req_kind_i == AMS_DMA_WR && req_addr_i[31:24] != 8'h00 |->
    ##1 idle_cmd [*8]) else $error("command above 16 Mbytes");
  dma_low_a: assert property (take && req_kind_i == AMS_DMA_WR && req_addr_i[31:24] == 8'h00 |->
    ##3 !mem_write_cmd_n_o) else $error("dma write missing");
  fast_quiet_a: assert property (take && req_kind_i == AMS_FAST_DMA |=>
    (idle_cmd && !system_byte_addr_oe_o) [*8]) else $error("fast dma drove bus");
  takeover_a: assert property (grab && req_ready_o |=> ext_owner_o) else $error("takeover missed");
  owner_kept_a: assert property (ext_owner_o && !ext_master_n_i |=> ext_owner_o)
    else $error("bus taken back early");
  owner_float_a: assert property (ext_owner_o |->
    !(mem_read_cmd_n_oe_o || mem_write_cmd_n_oe_o || system_byte_addr_oe_o)) else $error("driver not released");
endmodule
bind ams_isa_addr_mem ams_isa_addr_mem_checker i_ams_isa_addr_mem_checker (.*);

// ==== tb/ams_isa_partner.sv ====
`timescale 1ns/1ns
// Far side of the bus: one wide memory slave and one external bus master.
module ams_isa_partner
  import ams_pkg::*;
#(
  parameter logic [LA_W-1:0] SLV_LO = 7'h00,
  parameter logic [LA_W-1:0] SLV_HI = 7'h07
)
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Wires seen on the bus.
  input wire logic [LA_W-1:0] la_i,
  input wire logic strobe_i,
  input wire logic dma_grant_n_i,
  // Bench control of the master.
  input wire logic want_i,
  input wire logic rd_i,
  input wire logic [LA_W-1:0] addr_i,
  // Drivers of the master and the slave.
  output logic own_n_o,
  output logic oe_o,
  output logic [LA_W-1:0] la_o,
  output logic [SA_W-1:0] sa_o,
  output logic rd_n_o,
  output logic pull_o,
  output logic [LA_W-1:0] held_o
);
  // Slave select from the upper address alone; its data lanes lie outside this block.
  assign pull_o = la_i >= SLV_LO && la_i <= SLV_HI;
  // Ownership only after the grant is seen.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      own_n_o <= 1'b1;
    else if (!want_i)
      own_n_o <= 1'b1;
    else if (!dma_grant_n_i)
      own_n_o <= 1'b0;
  // Upper address captured at the strobe fall.
  always_ff @(negedge strobe_i)
    held_o <= la_i;
  assign oe_o = !own_n_o;
  assign la_o = addr_i;
  assign sa_o = {addr_i[2:0], 17'h00000};
  assign rd_n_o = !rd_i;
endmodule

// ==== tb/ams_isa_addr_mem_test.sv ====
`timescale 1ns/1ns
// Self-checking bench for the address and memory command block.
module ams_isa_addr_mem_test
  import ams_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid = 1'b0;
  logic req_hi = 1'b0;
  logic grant_n = 1'b1;
  logic want = 1'b0;
  logic prd = 1'b0;
  ams_kind_type req_kind = AMS_MEM_RD;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] seed = 32'h16;
  logic [31:0] cyc = 32'h0;
  logic [6:0] paddr = 7'h0;
  logic [6:0] fwd_lo = 7'h10;
  logic [6:0] fwd_hi = 7'h1f;
  int error_cnt = 0;
  int cmp_count = 0;
  wire ready, done, own, own_n, la_oe, sa_oe, be_o, be_oe, ws_o, ws_oe, rd_o, rd_oe, wr_o, wr_oe;
  wire strobe, lrd, lwr, p_oe, p_rd, pull;
  wire [6:0] la_o, p_la, held;
  wire [19:0] sa_o, p_sa;
  // Wires resolved from all drivers; floating lines change each cycle, commands and select are pulled up.
  wire [6:0] la_w = la_oe ? la_o : p_oe ? p_la : cyc[6:0];
  wire [19:0] sa_w = sa_oe ? sa_o : p_oe ? p_sa : ~cyc[19:0];
  wire be_w = be_oe ? be_o : cyc[0];
  wire rd_w = rd_oe ? rd_o : p_oe ? p_rd : 1'b1;
  wire wr_w = wr_oe ? wr_o : 1'b1;
  wire ws_w = !((ws_oe && !ws_o) || pull);

  ams_isa_addr_mem i_ams_isa_addr_mem (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
    .req_kind_i(req_kind), .req_addr_i(req_addr), .req_hi_byte_i(req_hi), .req_ready_o(ready),
    .req_done_o(done), .dma_grant_n_i(grant_n), .ext_master_n_i(own_n), .ext_owner_o(own),
    .fwd_base_i(fwd_lo), .fwd_top_i(fwd_hi), .unlatched_upper_addr_i(la_w), .unlatched_upper_addr_o(la_o),
    .unlatched_upper_addr_oe_o(la_oe), .system_byte_addr_i(sa_w), .system_byte_addr_o(sa_o),
    .system_byte_addr_oe_o(sa_oe), .upper_byte_enable_n_i(be_w), .upper_byte_enable_n_o(be_o),
    .upper_byte_enable_n_oe_o(be_oe), .wide_memory_select_n_i(ws_w), .wide_memory_select_n_o(ws_o),
    .wide_memory_select_n_oe_o(ws_oe), .mem_read_cmd_n_i(rd_w), .mem_read_cmd_n_o(rd_o),
    .mem_read_cmd_n_oe_o(rd_oe), .mem_write_cmd_n_i(wr_w), .mem_write_cmd_n_o(wr_o),
    .mem_write_cmd_n_oe_o(wr_oe), .addr_latch_strobe_o(strobe), .low_mem_read_cmd_n_o(lrd),
    .low_mem_write_cmd_n_o(lwr));
  ams_isa_partner i_ams_isa_partner (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .la_i(la_w),
    .strobe_i(strobe), .dma_grant_n_i(grant_n), .want_i(want), .rd_i(prd), .addr_i(paddr), .own_n_o(own_n),
    .oe_o(p_oe), .la_o(p_la), .sa_o(p_sa), .rd_n_o(p_rd), .pull_o(pull), .held_o(held));

  // Clock and a free cycle count for floating lines.
  initial
  begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
    cyc <= cyc + 32'h1;

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A bounded wait that ran out ends the run.
  task automatic tmo(input logic ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1)
      stop_test();
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected command pin levels {read, write}, active low, for a request.
  function automatic logic [1:0] exp_cmd(input ams_kind_type k, input logic [31:0] a);
    logic low;
    logic rd;
    logic wr;
    low = a[31:24] == 8'h00;
    rd = k == AMS_MEM_RD || k == AMS_REFRESH || (k == AMS_DMA_RD && low);
    wr = k == AMS_MEM_WR || (k == AMS_DMA_WR && low);
    return {!rd, !wr};
  endfunction

  // Runs one request and checks the pins in its address and command phases.
  task automatic run_req(input ams_kind_type k, input logic [31:0] a, input logic hi);
    logic [1:0] c;
    int n;
    c = exp_cmd(k, a);
    req_kind = k;
    req_addr = a;
    req_hi = hi;
    req_valid = 1'b1;
    for (n = 0; n < 40 && !ready; n++) tick();
    tmo(ready);
    tick();
    req_valid = 1'b0;
    chk({strobe, la_oe}, {1'b1, k != AMS_FAST_DMA});
    if (k != AMS_FAST_DMA)
      chk(la_w, a[23:17]);
    tick(2);
    chk({rd_w, wr_w}, c);
    if (k == AMS_FAST_DMA)
      chk(sa_oe, 1'b0);
    else if (k inside {AMS_IO_RD, AMS_IO_WR})
      chk(sa_w, {4'h0, a[15:0]});
    else
    begin
      chk({la_w, held}, {a[23:17], a[23:17]});
      chk(sa_w, a[19:0]);
    end
    if (k != AMS_FAST_DMA)
      chk(be_w, k == AMS_REFRESH || !hi);
    tick();
    chk({lrd, lwr}, c | {2{a[31:20] != 12'h000}});
    for (n = 0; n < 20 && !done; n++) tick();
    tmo(done);
    tick();
  endtask

  initial
  begin
    int i;
    logic [31:0] a;
    tick(4);
    chk({la_oe, sa_oe, be_oe, ws_oe, rd_o, wr_o}, 6'h03);
    tick(4);
    rst_n_i = 1'b1;
    $display("reset test done");
    run_req(AMS_DMA_RD, 32'h00ffffff, 1'b1);
    run_req(AMS_DMA_WR, 32'h01000000, 1'b0);
    for (i = 0; i < 32; i++)
    begin
      a = rnd();
      if (i[3])
        a[31:24] = 8'h00;
      if (i[4])
        a[31:20] = 12'h000;
      run_req(ams_kind_type'(i[2:0]), a, a[0]);
    end
    $display("request test done");
    want = 1'b1;
    paddr = 7'h12;
    tick(3);
    chk(own, 1'b0);
    grant_n = 1'b0;
    for (i = 0; i < 10 && !own; i++) tick();
    tmo(own);
    tick(2);
    chk({rd_oe, wr_oe, sa_oe, ws_oe, ws_w}, 5'h02);
    paddr = 7'h05;
    prd = 1'b1;
    tick(2);
    chk({ws_oe, ws_w, lrd, own}, 4'h1);
    paddr = 7'h12;
    tick(2);
    chk({lrd, own}, 2'h3);
    fwd_lo = 7'h00;
    fwd_hi = 7'h11;
    tick(2);
    chk({ws_oe, ws_w}, 2'h1);
    want = 1'b0;
    prd = 1'b0;
    grant_n = 1'b1;
    for (i = 0; i < 10 && own; i++) tick();
    tmo(!own);
    chk({rd_oe, wr_oe}, 2'h3);
    $display("takeover test done");
    stop_test();
  end
endmodule
